// *** include/adcs_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * conversion sequencer. Assumes inclusion by the top module and the tick generator.
 */
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH

`define ADCS_OFF_CTRL      4'h0
`define ADCS_OFF_PCFG      4'h1
`define ADCS_OFF_RESULT    4'h2
`define ADCS_OFF_IRQ_STAT  4'h3
`define ADCS_OFF_IRQ_EN    4'h4
`define ADCS_OFF_IRQ_CLR   4'h5
`define ADCS_OFF_PORT      4'h6
`define ADCS_OFF_DIR       4'h7

`define ADCS_CTRL_ON       0
`define ADCS_CTRL_GO       2
`define ADCS_CTRL_CHAN_LO  3
`define ADCS_CTRL_CLK_LO   6

`define ADCS_CTRL_RST      8'h00
`define ADCS_PCFG_RST      8'h00
`define ADCS_DIR_RST       8'hFF
`define ADCS_RESULT_RST    8'h00

`define ADCS_CONV_HALVES   19
`define ADCS_RECOV_HALVES  4
`define ADCS_DIV_FAST      2
`define ADCS_DIV_MID       8
`define ADCS_DIV_SLOW      32
`define ADCS_RC_DIV        400

`endif

// *** include/adcs_pkg.sv ***
/*
 * Types of the conversion sequencer.
 * Assumes the map header sits in the include path.
 */
`default_nettype none
package adcs_pkg;
    typedef enum logic [2:0] {
        ADCS_IDLE  = 3'b001,
        ADCS_CONV  = 3'b010,
        ADCS_RECOV = 3'b100
    } adcs_state_e;

    typedef logic [7:0] adcs_byte_t;
endpackage : adcs_pkg
`default_nettype wire

// *** rtl/adcs_sequencer.sv ***
/*
 * Conversion sequencer for an 8-bit successive approximation converter:
 * control, port configuration, result, interrupt registers and timing.
 * Assumes a comparator on the analog side answering each trial, and
 * port pins arriving asynchronously.
 */
// The address-and-strobe port and the address map were chosen for this implementation.
// Notes on behaviour
// - A full conversion lasts nine and a half bit periods.
// - Clock select 00/01/10 gives 2, 8, 32 oscillator periods; 11 internal RC.
// - Two bit periods of recovery follow a conversion, hold capacitor disconnected.
// - Clearing the start flag mid conversion aborts it at once.
// - An aborted conversion leaves the result untouched.
// - After abort, wait two bit periods then acquire the selected channel.
// - Completion sets the done flag and clears the start flag.
// - Port reads show zero on pins configured as analog.
// - Analog pins should be inputs; an output pin converts its driven level.
// - Conversion runs regardless of channel and direction settings.
// - The result loads together with the completion signal.
`include "adcs_map.svh"
`default_nettype none
module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter int RC_DIV = `ADCS_RC_DIV
) (
    input  wire logic           mclk_i,      // 100 MHz clock
    input  wire logic           rst_i,       // Sync reset
    input  wire logic [3:0]     addr_i,      // Register index
    input  wire adcs_pkg::adcs_byte_t wdata_i, // Write data
    input  wire logic           wr_i,        // Write strobe
    input  wire logic           rd_i,        // Read strobe
    output adcs_pkg::adcs_byte_t rdata_o,    // Read data
    input  wire logic           cmp_i,       // Comparator: input above trial
    input  wire logic [7:0]     pin_i,       // Port pin levels
    output logic [7:0]          trial_o,     // Trial code to DAC
    output logic [2:0]          chan_o,      // Selected channel
    output logic                hold_conn_o, // Hold capacitor connected
    output logic                irq_o        // Interrupt level
);
    typedef struct packed {
        adcs_state_e state;
        logic [7:0]  ctrl;
        logic [2:0]  pcfg;
        logic [7:0]  result;
        logic [7:0]  sar;
        logic [7:0]  dir;
        logic [4:0]  half_cnt;
        logic        done;
        logic        done_en;
        logic [7:0]  rdata;
        logic [7:0]  trial;
        logic [2:0]  chan;
        logic        hold;
        logic        restart;
        logic        irq;
        logic [7:0]  pin_a;
        logic [7:0]  pin_b;
    } adcs_state_s;

    adcs_state_s st_r;
    adcs_state_s st_nxt;
    logic        tick;
    logic        running;
    logic [7:0]  analog_mask;
    logic [2:0]  bit_idx;
    logic        go_write;
    logic        go_clear;

    if (RC_DIV < 4 || RC_DIV > 65535) begin : g_bad_div
        $error("RC_DIV out of range");
    end

    assign running = (st_r.state != ADCS_IDLE);

    adcs_tick_gen #(
        .RC_DIV (RC_DIV)
    ) u_tick (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .run_i  (running && !st_r.restart),
        .sel_i  (st_r.ctrl[`ADCS_CTRL_CLK_LO +: 2]),
        .tick_o (tick)
    );

    // Analog pin map from port configuration
    always_comb begin
        case (st_r.pcfg)
            3'b000, 3'b001: analog_mask = 8'hFF;
            3'b010, 3'b011: analog_mask = 8'h1F;
            3'b100, 3'b101: analog_mask = 8'h0B;
            default:        analog_mask = 8'h00;
        endcase
    end

    assign go_write = wr_i && addr_i == `ADCS_OFF_CTRL;
    assign go_clear = go_write && !wdata_i[`ADCS_CTRL_GO];

    always_comb begin
        st_nxt       = st_r;
        st_nxt.pin_a = pin_i;
        st_nxt.pin_b = st_r.pin_a;
        st_nxt.restart = 1'b0;
        bit_idx      = 3'(7 - (st_r.half_cnt >> 1));

        if (wr_i) begin
            case (addr_i)
                `ADCS_OFF_CTRL:    st_nxt.ctrl = {wdata_i[7:3], wdata_i[`ADCS_CTRL_GO] && st_r.ctrl[`ADCS_CTRL_ON],
                                                  1'b0, wdata_i[0]};
                `ADCS_OFF_PCFG:    st_nxt.pcfg = wdata_i[2:0];
                `ADCS_OFF_RESULT:  st_nxt.result = wdata_i;
                `ADCS_OFF_IRQ_EN:  st_nxt.done_en = wdata_i[0];
                `ADCS_OFF_IRQ_CLR: if (wdata_i[0]) st_nxt.done = 1'b0;
                `ADCS_OFF_DIR:     st_nxt.dir = wdata_i;
                default:           st_nxt.ctrl = st_r.ctrl;
            endcase
        end

        case (st_r.state)
            ADCS_IDLE: begin
                st_nxt.hold = st_r.ctrl[`ADCS_CTRL_ON];
                // A start only counts when the converter was already on
                if (st_r.ctrl[`ADCS_CTRL_GO] && st_r.ctrl[`ADCS_CTRL_ON]) begin
                    st_nxt.state    = ADCS_CONV;
                    st_nxt.half_cnt = 5'h00;
                    st_nxt.sar      = 8'h00;
                    st_nxt.trial    = 8'h80;
                    st_nxt.hold     = 1'b0;
                end else if (st_r.ctrl[`ADCS_CTRL_GO]) begin
                    st_nxt.ctrl[`ADCS_CTRL_GO] = 1'b0;
                end
            end
            ADCS_CONV: begin
                st_nxt.hold = 1'b0;
                if (go_clear || !st_r.ctrl[`ADCS_CTRL_ON]) begin
                    st_nxt.state    = ADCS_RECOV;
                    st_nxt.half_cnt = 5'h00;
                    // Realign the tick so the wait is never cut short
                    st_nxt.restart  = 1'b1;
                end else if (tick) begin
                    st_nxt.half_cnt = st_r.half_cnt + 5'h01;
                    // Decide one bit at the end of each of the first eight full periods
                    if (st_r.half_cnt[0] && st_r.half_cnt < 5'd16) begin
                        st_nxt.sar[bit_idx] = cmp_i;
                        st_nxt.trial        = (st_r.sar | (8'(cmp_i) << bit_idx));
                        if (bit_idx != 3'd0) begin
                            st_nxt.trial[bit_idx - 3'd1] = 1'b1;
                        end
                    end
                    if (st_r.half_cnt + 5'h01 == 5'(`ADCS_CONV_HALVES)) begin
                        st_nxt.result               = st_r.sar;
                        st_nxt.done                 = 1'b1;
                        st_nxt.ctrl[`ADCS_CTRL_GO] = 1'b0;
                        st_nxt.state                = ADCS_RECOV;
                        st_nxt.half_cnt             = 5'h00;
                    end
                end
            end
            ADCS_RECOV: begin
                st_nxt.hold = 1'b0;
                if (tick && !st_r.restart) begin
                    st_nxt.half_cnt = st_r.half_cnt + 5'h01;
                    if (st_r.half_cnt + 5'h01 == 5'(`ADCS_RECOV_HALVES)) begin
                        st_nxt.state                = ADCS_IDLE;
                        st_nxt.ctrl[`ADCS_CTRL_GO] = 1'b0;
                        st_nxt.half_cnt             = 5'h00;
                    end
                end
            end
            default: st_nxt.state = ADCS_IDLE;
        endcase

        // A start written while recovering is cleared when recovery ends; only an idle write starts a conversion
        if (go_write && wdata_i[`ADCS_CTRL_GO] && st_r.state == ADCS_IDLE && st_r.ctrl[`ADCS_CTRL_ON]) begin
            st_nxt.ctrl[`ADCS_CTRL_GO] = 1'b1;
        end
        if (go_write && wdata_i[`ADCS_CTRL_GO] && st_r.state == ADCS_CONV) begin
            st_nxt.ctrl[`ADCS_CTRL_GO] = st_nxt.ctrl[`ADCS_CTRL_GO];
        end

        st_nxt.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `ADCS_OFF_CTRL:     st_nxt.rdata = {st_r.ctrl[7:3], running && st_r.state == ADCS_CONV
                                                    ? 1'b1 : st_r.ctrl[2], 1'b0, st_r.ctrl[0]};
                `ADCS_OFF_PCFG:     st_nxt.rdata = {5'h00, st_r.pcfg};
                `ADCS_OFF_RESULT:   st_nxt.rdata = st_r.result;
                `ADCS_OFF_IRQ_STAT: st_nxt.rdata = {7'h00, st_r.done};
                `ADCS_OFF_IRQ_EN:   st_nxt.rdata = {7'h00, st_r.done_en};
                `ADCS_OFF_PORT:     st_nxt.rdata = st_r.pin_b & ~analog_mask;
                `ADCS_OFF_DIR:      st_nxt.rdata = st_r.dir;
                default:            st_nxt.rdata = 8'h00;
            endcase
        end

        // Event set wins over a same-cycle clear
        if (st_r.state == ADCS_CONV && tick && !go_clear && st_r.ctrl[`ADCS_CTRL_ON]
            && st_r.half_cnt + 5'h01 == 5'(`ADCS_CONV_HALVES)) begin
            st_nxt.done = 1'b1;
        end
        st_nxt.chan = st_nxt.ctrl[`ADCS_CTRL_CHAN_LO +: 3];
        st_nxt.irq  = st_nxt.done && st_nxt.done_en;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r          <= '0;
            st_r.state    <= ADCS_IDLE;
            st_r.ctrl     <= `ADCS_CTRL_RST;
            st_r.pcfg     <= 3'(`ADCS_PCFG_RST);
            st_r.dir      <= `ADCS_DIR_RST;
            st_r.result   <= `ADCS_RESULT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o     = st_r.rdata;
    assign trial_o     = st_r.trial;
    assign chan_o      = st_r.chan;
    assign hold_conn_o = st_r.hold;
    assign irq_o       = st_r.irq;
endmodule : adcs_sequencer
`default_nettype wire

// *** rtl/adcs_tick_gen.sv ***
/*
 * Half bit period tick generator for the conversion clock.
 * Assumes a single clock and synchronous active high reset.
 */
`include "adcs_map.svh"
`default_nettype none
module adcs_tick_gen #(
    parameter int RC_DIV = `ADCS_RC_DIV
) (
    input  wire logic       mclk_i,     // System clock
    input  wire logic       rst_i,      // Sync reset
    input  wire logic       run_i,      // Counting enable
    input  wire logic [1:0] sel_i,      // Clock source code
    output logic            tick_o      // Half period pulse
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } adcs_tick_s;

    adcs_tick_s st_r;
    adcs_tick_s st_nxt;
    logic [15:0] half;

    if (RC_DIV < 4 || RC_DIV > 65535) begin : g_bad_div
        $error("RC_DIV out of range");
    end

    always_comb begin
        case (sel_i)
            2'b00:   half = 16'(`ADCS_DIV_FAST / 2);
            2'b01:   half = 16'(`ADCS_DIV_MID / 2);
            2'b10:   half = 16'(`ADCS_DIV_SLOW / 2);
            default: half = 16'(RC_DIV / 2);
        endcase
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!run_i) begin
            st_nxt.cnt = 16'h0000;
        end else if (st_r.cnt + 16'h0001 >= half) begin
            st_nxt.cnt  = 16'h0000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule : adcs_tick_gen
`default_nettype wire

// *** tb/adcs_front_model.sv ***
/*
 * Analog front end: sample and hold with comparator.
 * Assumes channel levels given by the bench, eight bits per channel.
 */
`default_nettype none
module adcs_front_model (
    input  wire logic        mclk_i,      // Clock
    input  wire logic [7:0]  trial_i,     // Trial code
    input  wire logic [2:0]  chan_i,      // Channel
    input  wire logic        hold_conn_i, // Hold connected
    input  wire logic [63:0] level_i,     // Channel levels
    output logic             cmp_o        // Held level >= trial
);
    logic [7:0] held_r = 8'h00;
    // Tracks the input only while connected
    always @(posedge mclk_i) begin
        if (hold_conn_i) begin
            held_r <= level_i[chan_i*8 +: 8];
        end
    end
    assign cmp_o = (held_r >= trial_i);
endmodule : adcs_front_model
`default_nettype wire

// *** tb/adcs_seq_monitor.sv ***
/*
 * Port checker for the conversion sequencer, bound to its top module.
 * Assumes one clock domain with synchronous active high reset.
 */
`default_nettype none
module adcs_seq_monitor
    import adcs_pkg::*;
(
    input wire logic                 mclk_i,      // Clock
    input wire logic                 rst_i,       // Reset
    input wire logic [3:0]           addr_i,      // Index
    input wire adcs_pkg::adcs_byte_t wdata_i,     // Write data
    input wire logic                 wr_i,        // Write strobe
    input wire logic                 rd_i,        // Read strobe
    input wire adcs_pkg::adcs_byte_t rdata_o,     // Read data
    input wire logic [2:0]           chan_o,      // Channel
    input wire logic                 hold_conn_o, // Hold connected
    input wire logic                 irq_o        // Interrupt
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    hold_min_a: assert property ($fell(hold_conn_o) |-> !hold_conn_o [*4])
        else $error("hold reconnected too early");
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    unmap_read_a: assert property (rd_i && addr_i[3] |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    irq_rise_a: assert property ($rose(irq_o) && !$past(wr_i) |-> !hold_conn_o)
        else $error("interrupt rose outside completion");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_i))
        else $error("interrupt fell without write");
    chan_hold_a: assert property (!$past(wr_i) |-> $stable(chan_o))
        else $error("channel changed without write");
    chan_wr_a: assert property (wr_i && addr_i == 4'h0 |-> ##2 chan_o == $past(wdata_i[5:3], 2))
        else $error("channel not taken from write");
    off_disc_a: assert property (wr_i && addr_i == 4'h0 && !wdata_i[0] |=> ##1 !hold_conn_o)
        else $error("hold connected while off");

    cover property ($rose(irq_o));
    cover property ($fell(hold_conn_o));
    cover property (rd_i && addr_i == 4'h6);
endmodule : adcs_seq_monitor

bind adcs_sequencer adcs_seq_monitor u_mon (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .chan_o(chan_o), .hold_conn_o(hold_conn_o), .irq_o(irq_o)
);
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Self-checking bench of the conversion sequencer.
 * Assumes the package, map header and front end model are compiled first.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcs_pkg::*;
    localparam int RC = 160;  // RC bit period of 1.6 us
    logic        mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, rd_d = 0, cmp, hold, irq;
    logic [3:0]  addr_i = 0;
    logic [7:0]  pins = 0;
    logic [63:0] lv = 0;
    logic [2:0]  chan;
    adcs_byte_t  wdata_i = 0, rdata_o, trial, v, m, q[$];
    int          failures = 0, n_checks = 0, n;

    adcs_sequencer #(.RC_DIV(RC)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_i(cmp), .pin_i(pins),
        .trial_o(trial), .chan_o(chan), .hold_conn_o(hold), .irq_o(irq));
    adcs_front_model u_fe (.mclk_i(mclk_i), .trial_i(trial), .chan_i(chan), .hold_conn_i(hold),
        .level_i(lv), .cmp_o(cmp));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic test_done;
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
    endtask : cyc

    task automatic wr(input logic [3:0] a, input adcs_byte_t d);
        @(posedge mclk_i);
        wr_i <= 1; addr_i <= a; wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input adcs_byte_t e);
        @(posedge mclk_i);
        rd_i <= 1; addr_i <= a; q.push_back(e);
        @(posedge mclk_i);
        rd_i <= 0;
    endtask : rd

    // Counts settled cycles until the output reaches the level
    task automatic wfor(ref logic s, output int k);
        k = 0;
        while (s !== 1'b1 && k < 2000) begin
            @(negedge mclk_i);
            k++;
        end
    endtask : wfor

    always @(posedge mclk_i) rd_d <= rd_i;

    always @(negedge mclk_i) begin : watch
        adcs_byte_t e;
        if (rd_d === 1'b1) begin
            e = q.pop_front();
            chk(rdata_o === e, rdata_o, e);
        end
    end

    initial begin
        #500us;
        failures++;
        test_done;
    end

    initial begin
        void'($urandom(32'haab017c4));
        cyc(6);
        rst_i <= 0;
        rd(0, 0); rd(1, 0); rd(2, 0); rd(3, 0); rd(7, 8'hFF); rd(4'h9, 0);
        wr(4, 1);
        for (int c = 0; c < 4; c++) begin
            int h;
            logic [63:0] r;
            h = (c == 3) ? RC / 2 : (2 << (2 * c)) / 2;
            v = 8'($urandom);
            r = {$urandom, $urandom};
            r[c*8 +: 8] = v;
            lv <= r;
            wr(7, 8'($urandom));
            wr(0, {c[1:0], c[2:0], 3'b001});
            cyc(20);
            wr(0, {c[1:0], c[2:0], 3'b101});
            wfor(irq, n); chk(n >= 19 * h && n <= 20 * h + 3, n, 19 * h);
            wfor(hold, n); chk(n >= 4 * h - 1 && n <= 5 * h + 3, n, 4 * h);
            rd(2, v);
            rd(0, {c[1:0], c[2:0], 3'b001});
            rd(3, 1);
            wr(5, 1); rd(3, 0); chk(irq === 1'b0, irq, 0);
        end
        lv[7:0] <= ~v;
        wr(0, 8'b01_000_001); cyc(20);
        wr(0, 8'b01_000_101); cyc(20);
        wr(0, 8'b01_000_001);
        wfor(hold, n); chk(n >= 15 && n <= 23, n, 16);
        rd(2, v);
        rd(3, 0);
        wr(4, 0); wr(0, 8'b00_001_101); cyc(40);
        chk(irq === 1'b0, irq, 0); rd(3, 1);
        wr(4, 1); cyc(2); chk(irq === 1'b1, irq, 1);
        wr(5, 1); cyc(2); chk(irq === 1'b0, irq, 0);
        wr(0, 0); cyc(10); wr(0, 8'h05); cyc(60); rd(3, 0);
        rd(0, 8'h01);
        for (int p = 0; p < 8; p++) begin
            pins <= 8'($urandom);
            wr(1, p[7:0]); cyc(4);
            m = p < 2 ? 8'hFF : p < 4 ? 8'h1F : p < 6 ? 8'h0B : 8'h00;
            rd(6, pins & ~m);
        end
        rst_i <= 1; cyc(6); rst_i <= 0;
        rd(0, 0); rd(7, 8'hFF);
        cyc(4);
        test_done;
    end
endmodule : tb_top
`default_nettype wire
